// *** ifd_pkg.sv ***
// Constants, field layout and register map of the instruction field decoder
// Summary of operation
// RULE1: Split 32-bit word into five fields
// RULE2: Register select picks one of 16
// RULE3: Tag picks direct, indexed, indirect, indexed-indirect
// RULE4: Tag top bit indirect, low three index
// RULE5: Index registers live at locations 21-27
// RULE6: Index scaled by operand size
// RULE7: Nonzero base select adds 24-bit base
// RULE8: Base select zero adds no base
// RULE9: Immediate opcodes deliver base plus displacement
// RULE10: Fixed word is 32-bit twos complement
// RULE11: Fixed halfword is 16-bit, two per word
// RULE12: Float word sign bit 0, fraction 8-31
// RULE13: Exponent biased by 40 hex, base sixteen
// RULE14: Decode arithmetic, logical and circular shifts
// RULE15: Decode subtract and subtract-magnitude opcodes
// RULE16: Decode single-register store opcodes
// RULE17: Decode register file stores 2B, 2F
// RULE18: Decode negated and complement store opcodes
// RULE19: Decode indexed halfword store routing
// RULE20: Decode clock store and status store
// RULE21: Vector execute form from register select
// RULE22: Vector map illegal and four-pipe codes
// RULE23: Float double sign bit 0, fraction 8-63
// RULE24: Illegal opcode flagged, never dispatched
package ifd_pkg;
  // Field positions, bit 31 is the word's leading bit
  localparam int OP_LSB = 24;
  localparam int R_LSB = 20;
  localparam int T_LSB = 16;
  localparam int M_LSB = 12;
  localparam int N_W = 12;
  localparam logic [6:0] EXP_BIAS = 7'h40;
  // Register byte offsets
  localparam logic [7:0] A_INSTR = 8'h00;
  localparam logic [7:0] A_CONFIG = 8'h04;
  localparam logic [7:0] A_FIELDS = 8'h08;
  localparam logic [7:0] A_ADDR = 8'h0c;
  localparam logic [7:0] A_IMM = 8'h10;
  localparam logic [7:0] A_CLASS = 8'h14;
  localparam logic [7:0] A_OPHI = 8'h18;
  localparam logic [7:0] A_OPLO = 8'h1c;
  localparam logic [7:0] A_FLOAT = 8'h20;
  localparam logic [7:0] A_HALF_L = 8'h24;
  localparam logic [7:0] A_HALF_R = 8'h28;
  localparam logic [7:0] A_SIGNS = 8'h2c;
  localparam logic [7:0] A_VOP = 8'h30;
  localparam logic [7:0] A_VSTAT = 8'h34;
  localparam logic [5:0] BASE_IDX = 6'h10;
  localparam logic [5:0] INDEX_IDX = 6'h20;
  // Opcodes handled by name
  localparam logic [7:0] OP_VECTOR_RUN = 8'hb0;
  localparam logic [7:0] OP_STORE_CLOCK = 8'hae;
  localparam logic [7:0] OP_STORE_STATUS = 8'h22;
  localparam logic [7:0] OP_STORE_FILE = 8'h2b;
  localparam logic [7:0] OP_STORE_ALL = 8'h2f;
  // Legal scalar opcodes, bit n for opcode n
  localparam logic [255:0] SCALAR_LEGAL = 256'h1154_33fc_4300_befb_0001_7f07_c8df_ff0f_3530_f5f0_1374_ff00_ffff_ffff_ffff_0000;
  // Opcodes whose base and displacement form an immediate
  localparam logic [255:0] IMM_OPS = 256'h1154_0000_4300_b0fb_0000_0000_0011_0000_3530_0000_1330_0000_0000_0000_0040_0000;
  typedef enum logic [1:0] {SZ_HALF, SZ_WORD, SZ_DOUBLE} size_t;
  typedef enum logic [1:0] {GRP_ARITH, GRP_BASE, GRP_INDEX} group_t;
endpackage

// *** instruction_field_decode.sv ***
// Instruction field decoder with Wishbone register access
`timescale 1ns/100ps
`default_nettype none
module instruction_field_decode
  import ifd_pkg::*;
#(
  parameter int BASE_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic dispatch_o,
  output logic illegal_o
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (BASE_W < 16 || BASE_W > 32) begin : g_bad
    $error("BASE_W must lie between 16 and 32");
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake
  logic ack_r;
  logic [31:0] dat_r;
  logic req;
  logic wr;
  assign req = cyc_i & stb_i;
  // Write lands on the edge where the master sees ack
  assign wr = req & we_i & ack_r;

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (sel_i[b]) begin
        v[8*b +: 8] = dat_i[8*b +: 8];
      end
    end
    return v;
  endfunction

  // One-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end
  assign ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [31:0] instr_r;
  logic four_pipe_r;
  logic [31:0] opnd_hi_r;
  logic [31:0] opnd_lo_r;
  logic [7:0] vop_r;
  logic go_r;
  logic vgo_r;
  logic [31:0] base_r [1:15];
  logic [31:0] index_r [1:7];

  // Instruction, configuration and operand words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_r <= 32'h0000_0000;
      four_pipe_r <= 1'b1;
      opnd_hi_r <= 32'h0000_0000;
      opnd_lo_r <= 32'h0000_0000;
      vop_r <= 8'h00;
      go_r <= 1'b0;
      vgo_r <= 1'b0;
    end else begin
      go_r <= wr && adr_i == A_INSTR;
      vgo_r <= wr && adr_i == A_VOP;
      if (wr && adr_i == A_INSTR) begin
        instr_r <= merge(instr_r); // RULE1
      end
      if (wr && adr_i == A_CONFIG && sel_i[0]) begin
        four_pipe_r <= dat_i[0];
      end
      if (wr && adr_i == A_OPHI) begin
        opnd_hi_r <= merge(opnd_hi_r);
      end
      if (wr && adr_i == A_OPLO) begin
        opnd_lo_r <= merge(opnd_lo_r);
      end
      if (wr && adr_i == A_VOP && sel_i[0]) begin
        vop_r <= dat_i[7:0];
      end
    end
  end

  // Base registers, one word each above the base window
  for (genvar i = 1; i < 16; i++) begin : g_base
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        base_r[i] <= 32'h0000_0000;
      end else if (wr && adr_i[7:2] == BASE_IDX + 6'(i)) begin
        base_r[i] <= merge(base_r[i]);
      end
    end
  end

  // Index registers at locations 21 to 27
  for (genvar i = 1; i < 8; i++) begin : g_index
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        index_r[i] <= 32'h0000_0000;
      end else if (wr && adr_i[7:2] == INDEX_IDX + 6'(i)) begin
        index_r[i] <= merge(index_r[i]); // RULE5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field split
  logic [7:0] op;
  logic [3:0] rsel;
  logic [3:0] tag;
  logic [3:0] msel;
  logic [N_W-1:0] disp;
  assign op = instr_r[OP_LSB +: 8]; // RULE1
  assign rsel = instr_r[R_LSB +: 4];
  assign tag = instr_r[T_LSB +: 4];
  assign msel = instr_r[M_LSB +: 4];
  assign disp = instr_r[N_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Opcode classification
  size_t size;
  group_t grp;
  logic is_shift;
  logic [1:0] shift_kind;
  logic is_sub;
  logic is_submag;
  logic is_float;
  logic is_store;
  logic [2:0] store_kind;
  logic [1:0] half_route;
  logic is_file;
  logic is_all;

  // Size and family of each recognised opcode
  always_comb begin
    size = SZ_WORD;
    grp = GRP_ARITH; // RULE2
    is_shift = 1'b0;
    shift_kind = 2'd0;
    is_sub = 1'b0;
    is_submag = 1'b0;
    is_float = 1'b0;
    is_store = 1'b0;
    store_kind = 3'd0;
    half_route = 2'd0;
    is_file = 1'b0;
    is_all = 1'b0;
    case (op)
      8'hc0, 8'hc1, 8'hc3: begin
        is_shift = 1'b1; // RULE14
        shift_kind = 2'd1;
      end
      8'hc4, 8'hc5, 8'hc7: begin
        is_shift = 1'b1; // RULE14
        shift_kind = 2'd2;
      end
      8'hcc, 8'hcd, 8'hcf: begin
        is_shift = 1'b1; // RULE14
        shift_kind = 2'd3;
      end
      8'h48, 8'h49, 8'h4a, 8'h4b,
      8'h4c, 8'h4d, 8'h4e, 8'h4f: begin
        is_sub = 1'b1; // RULE15
        is_submag = op[2];
        is_float = op[1];
      end
      8'h24, 8'h27, 8'h28, 8'h2c: begin
        is_store = 1'b1; // RULE16
        store_kind = 3'd1;
      end
      8'h2b: begin
        is_store = 1'b1; // RULE17
        is_file = 1'b1;
      end
      8'h2f: begin
        is_store = 1'b1; // RULE17
        is_all = 1'b1;
      end
      8'h34, 8'h35, 8'h36, 8'h37: begin
        is_store = 1'b1; // RULE18
        store_kind = 3'd2;
        is_float = op[1];
      end
      8'h2e, 8'h2a: begin
        is_store = 1'b1; // RULE18
        store_kind = 3'd3;
      end
      8'h25, 8'h29, 8'h26, 8'h2d: begin
        is_store = 1'b1; // RULE19
        store_kind = 3'd4;
      end
      8'hae: begin
        is_store = 1'b1; // RULE20
        store_kind = 3'd5;
      end
      8'h22: begin
        is_store = 1'b1; // RULE20
        store_kind = 3'd6;
      end
      default: begin
      end
    endcase
    // Halfword and doubleword variants
    case (op)
      8'hc1, 8'hc5, 8'hcd, 8'h49, 8'h4d, 8'h35, 8'h2a,
      8'h25, 8'h29, 8'h26, 8'h2d: size = SZ_HALF; // RULE11
      8'hc3, 8'hc7, 8'hcf, 8'h4b, 8'h4f, 8'h27, 8'h37: size = SZ_DOUBLE;
      default: begin
      end
    endcase
    // Route: bit1 source right half, bit0 target right half
    case (op)
      8'h25: half_route = 2'b00; // RULE19
      8'h29: half_route = 2'b01;
      8'h26: half_route = 2'b10;
      8'h2d: half_route = 2'b11;
      default: begin
      end
    endcase
    // Register group implied by the opcode
    case (op)
      8'h18, 8'h28, 8'h52, 8'h68, 8'h78: grp = GRP_BASE; // RULE2
      8'h1c, 8'h2c, 8'h56, 8'h5c, 8'h6a, 8'h7a,
      8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'hde: grp = GRP_INDEX;
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Address formation
  logic [BASE_W-1:0] base_v;
  logic [BASE_W-1:0] idx_v;
  logic [BASE_W-1:0] scaled;
  logic [BASE_W-1:0] addr_v;
  logic indirect;
  logic immediate;

  assign indirect = tag[3]; // RULE4
  assign immediate = IMM_OPS[op]; // RULE9

  // Base, then scaled index, added to the displacement
  always_comb begin
    base_v = '0; // RULE8
    idx_v = '0;
    if (msel != 4'h0) begin
      base_v = base_r[msel][BASE_W-1:0]; // RULE7
    end
    if (tag[2:0] != 3'd0) begin
      idx_v = index_r[tag[2:0]][BASE_W-1:0]; // RULE3 RULE4
    end
    case (size)
      SZ_HALF: scaled = idx_v >> 1; // RULE6
      SZ_DOUBLE: scaled = idx_v << 1;
      default: scaled = idx_v;
    endcase
    addr_v = BASE_W'(disp) + base_v + scaled; // RULE3
  end

  ////////////////////////////////////////////////////////////////////////
  // Vector map legality: one row mask per column
  function automatic logic [15:0] vlegal(input logic [3:0] c);
    case (c)
      4'h4, 4'h5, 4'he: return 16'hffff;
      4'h6: return 16'hfff0;
      4'ha: return 16'h3f07;
      4'hb: return 16'hb9bb;
      4'hc: return 16'hb0bb;
      4'hd: return 16'hfbff;
      4'hf: return 16'hbbff;
      default: return 16'h0000;
    endcase
  endfunction

  // Codes that only the four-pipe build accepts
  function automatic logic [15:0] vfour(input logic [3:0] c);
    case (c)
      4'hb: return 16'h8189;
      4'he: return 16'hc800;
      4'hf: return 16'hbbf7;
      default: return 16'h0000;
    endcase
  endfunction

  logic [15:0] vleg_v;
  logic [15:0] vfour_v;
  logic v_ok;
  assign vleg_v = vlegal(vop_r[7:4]);
  assign vfour_v = vfour(vop_r[7:4]);
  assign v_ok = vleg_v[vop_r[3:0]] & (four_pipe_r | ~vfour_v[vop_r[3:0]]); // RULE22

  ////////////////////////////////////////////////////////////////////////
  // Decoded results, registered one cycle after the instruction write
  logic [31:0] class_r;
  logic [BASE_W-1:0] addr_r;
  logic [15:0] imm_r;
  logic [1:0] vstat_r;
  logic legal;
  assign legal = SCALAR_LEGAL[op]; // RULE24

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      class_r <= 32'h0000_0000;
      addr_r <= '0;
      imm_r <= 16'h0000;
      dispatch_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      dispatch_o <= go_r & legal; // RULE24
      if (go_r) begin
        illegal_o <= ~legal; // RULE24
        addr_r <= immediate ? '0 : addr_v;
        imm_r <= immediate ? instr_r[15:0] : 16'h0000; // RULE9
        class_r <= {6'd0, grp, is_float, is_submag, store_kind,
                    half_route, op == OP_VECTOR_RUN && rsel == 4'h0,
                    is_all, is_file ? rsel[2:0] : 3'd0, shift_kind,
                    size, op == OP_VECTOR_RUN, is_shift, is_sub,
                    is_store, immediate, indirect,
                    tag[2:0] != 3'd0, ~legal}; // RULE17 RULE21
      end
    end
  end

  // Vector code check result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vstat_r <= 2'b00;
    end else if (vgo_r) begin
      vstat_r <= {1'b1, ~v_ok}; // RULE22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand format views
  logic [6:0] unb_exp;
  logic [31:0] float_v;
  logic [31:0] signs_v;
  assign unb_exp = opnd_hi_r[30:24] - EXP_BIAS; // RULE13
  assign float_v = {opnd_hi_r[31], unb_exp, opnd_hi_r[23:0]}; // RULE12
  assign signs_v = {27'd0,
                    |{opnd_hi_r[23:0], opnd_lo_r}, // RULE23
                    opnd_hi_r[31], // RULE12
                    opnd_hi_r[15], // RULE11
                    opnd_hi_r[31], // RULE11
                    opnd_hi_r[31]}; // RULE10

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    if (adr_i == A_INSTR) begin
      rd = instr_r;
    end else if (adr_i == A_CONFIG) begin
      rd = {31'd0, four_pipe_r};
    end else if (adr_i == A_FIELDS) begin
      rd = {8'd0, op, rsel, tag, msel, indirect, tag[2:0]};
    end else if (adr_i == A_ADDR) begin
      rd = 32'(addr_r);
    end else if (adr_i == A_IMM) begin
      rd = {16'd0, imm_r};
    end else if (adr_i == A_CLASS) begin
      rd = class_r;
    end else if (adr_i == A_OPHI) begin
      rd = opnd_hi_r;
    end else if (adr_i == A_OPLO) begin
      rd = opnd_lo_r;
    end else if (adr_i == A_FLOAT) begin
      rd = float_v;
    end else if (adr_i == A_HALF_L) begin
      rd = {{16{opnd_hi_r[31]}}, opnd_hi_r[31:16]}; // RULE11
    end else if (adr_i == A_HALF_R) begin
      rd = {{16{opnd_hi_r[15]}}, opnd_hi_r[15:0]}; // RULE11
    end else if (adr_i == A_SIGNS) begin
      rd = signs_v;
    end else if (adr_i == A_VOP) begin
      rd = {24'd0, vop_r};
    end else if (adr_i == A_VSTAT) begin
      rd = {30'd0, vstat_r};
    end else if (adr_i[7:2] > BASE_IDX && adr_i[7:2] < BASE_IDX + 6'd16) begin
      rd = base_r[adr_i[5:2]];
    end else if (adr_i[7:2] > INDEX_IDX && adr_i[7:2] < INDEX_IDX + 6'd8) begin
      rd = index_r[adr_i[4:2]];
    end
  end

  // Read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (req & ~ack_r) begin
      dat_r <= rd;
    end
  end
  assign dat_o = dat_r;

endmodule
`default_nettype wire

// *** instruction_field_decode_assertions.sv ***
// Concurrent checks on the decoder's bus answers and decode outputs
`timescale 1ns/100ps
`default_nettype none
module instruction_field_decode_checker
  import ifd_pkg::*;
#(
  parameter int BASE_W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic dispatch_o,
  input wire logic illegal_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic req;
  logic wr_ins;
  // New request, and an instruction write at its ack edge
  assign req = cyc_i && stb_i && !ack_o;
  assign wr_ins = cyc_i && stb_i && we_i && ack_o && adr_i == A_INSTR;
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_next: assert property (req |=> ack_o)
    else $error("request not answered in the next cycle");
  a_no_stray_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("answer without a request");
  a_read_hold: assert property (ack_o && !we_i |=> $stable(dat_o))
    else $error("read data moved before the next request");
  a_no_base_zero: assert property (req && !we_i && adr_i == 8'h40 |=> dat_o == 32'h0)
    else $error("base select zero slot is not empty");
  a_decode_result: assert property (wr_ins |-> ##[2:3] (dispatch_o != illegal_o))
    else $error("instruction write gave no decode outcome");
  a_dispatch_cause: assert property (dispatch_o |-> $past(wr_ins, 2) || $past(wr_ins, 3))
    else $error("dispatch without an instruction write");
  a_dispatch_legal: assert property (dispatch_o |-> !illegal_o ##1 !dispatch_o)
    else $error("dispatch of an illegal code or dispatch too long");
  a_illegal_hold: assert property ($changed(illegal_o) |-> $past(wr_ins, 2) || $past(wr_ins, 3))
    else $error("illegal flag moved without a decode");
  // Main scenarios reached
  c_dispatch: cover property (dispatch_o);
  c_illegal: cover property ($rose(illegal_o));
  c_write_decode: cover property (wr_ins ##[2:3] dispatch_o);
endmodule
bind instruction_field_decode instruction_field_decode_checker #(.BASE_W(BASE_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dispatch_o(dispatch_o),
  .illegal_o(illegal_o));
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the instruction field decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import ifd_pkg::*;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic dispatch_o;
  logic illegal_o;
  int failures = 0;
  int checks_done = 0;
  int seed = 32'hb3aef802;
  int since = 9;
  logic seen;
  logic [63:0] rq[$];
  logic dq[$];
  logic [23:0] base_v [16];
  logic [23:0] idx_v [8];
  logic [31:0] ins;
  logic [31:0] w;
  logic [31:0] lo;
  logic [23:0] ea;
  logic [7:0] op;
  logic [3:0] m;
  logic [1:0] sz;
  // Shift codes: code, kind, size
  logic [11:0] sh_tab [9] = '{{8'hc0, 2'd1, 2'd1}, {8'hc1, 2'd1, 2'd0}, {8'hc3, 2'd1, 2'd2},
    {8'hc4, 2'd2, 2'd1}, {8'hc5, 2'd2, 2'd0}, {8'hc7, 2'd2, 2'd2}, {8'hcc, 2'd3, 2'd1},
    {8'hcd, 2'd3, 2'd0}, {8'hcf, 2'd3, 2'd2}};
  // Store codes: code, store kind, half route
  logic [12:0] st_tab [16] = '{{8'h24, 3'd1, 2'd0}, {8'h27, 3'd1, 2'd0}, {8'h28, 3'd1, 2'd0},
    {8'h2c, 3'd1, 2'd0}, {8'h34, 3'd2, 2'd0}, {8'h35, 3'd2, 2'd0}, {8'h36, 3'd2, 2'd0},
    {8'h37, 3'd2, 2'd0}, {8'h2e, 3'd3, 2'd0}, {8'h2a, 3'd3, 2'd0}, {8'h25, 3'd4, 2'd0},
    {8'h29, 3'd4, 2'd1}, {8'h26, 3'd4, 2'd2}, {8'h2d, 3'd4, 2'd3}, {8'hae, 3'd5, 2'd0},
    {8'h22, 3'd6, 2'd0}};
  // Vector codes: code, four-pipe setting, expected illegal
  logic [9:0] v_tab [6] = '{{8'h40, 1'b1, 1'b0}, {8'h00, 1'b1, 1'b1}, {8'hb0, 1'b1, 1'b0},
    {8'hb0, 1'b0, 1'b1}, {8'h40, 1'b0, 1'b0}, {8'haf, 1'b1, 1'b1}};

  instruction_field_decode u_instruction_field_decode (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dispatch_o(dispatch_o),
    .illegal_o(illegal_o));

  always #25 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // One classic bus cycle, held until ack is seen at a rising edge
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w_en;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack_o && n < 20);
    if (!ack_o) begin
      failures++;
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // Read with a noted expectation under a mask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    rq.push_back({mk, e & mk});
    wb(1'b0, a, $random(seed));
  endtask

  // Instruction write with its noted decode outcome, then settle
  task automatic run_ins(input logic [31:0] iw, input logic legal);
    dq.push_back(legal);
    wb(1'b1, A_INSTR, iw);
    repeat (5) @(posedge clk_i);
  endtask

  task automatic done(input string s);
    $display("test %s finished, %0d checks so far", s, checks_done);
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Compares read answers and decode outcomes with the oldest notes
  always @(posedge clk_i) begin
    if (ack_o && !we_i) begin
      if (rq.size() > 0) begin
        `CHK(dat_o & rq[0][63:32], rq[0][31:0])
        rq.delete(0);
      end else begin
        failures++;
      end
    end
    if (ack_o && we_i && adr_i == A_INSTR) begin
      since = 0;
      seen = 1'b0;
    end else if (since < 9) begin
      since++;
      seen = seen | dispatch_o;
      if (since == 5 && dq.size() > 0) begin
        `CHK({seen, illegal_o}, {dq[0], !dq[0]})
        dq.delete(0);
      end
    end
  end

  // Watchdog, far beyond the expected run length
  initial begin
    #500000;
    failures++;
    final_report;
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(A_INSTR, 32'h0, ALL);
    rd_chk(A_CONFIG, 32'h1, ALL);
    wb(1'b1, 8'h40, $random(seed));
    rd_chk(8'h40, 32'h0, ALL);
    done("reset");
    base_v[0] = 24'h0;
    idx_v[0] = 24'h0;
    for (int i = 1; i < 16; i++) begin
      base_v[i] = 24'($random(seed));
      wb(1'b1, 8'h40 + 8'(4 * i), {8'h0, base_v[i]});
      if (i < 8) begin
        idx_v[i] = 24'($random(seed) & 255);
        wb(1'b1, 8'h80 + 8'(4 * i), {8'h0, idx_v[i]});
      end
    end
    for (int t = 0; t < 16; t++) begin
      op = 8'h48 + 8'(t % 8);
      m = 4'($random(seed));
      sz = (op[1:0] == 2'd1) ? 2'd0 : (op[1:0] == 2'd3) ? 2'd2 : 2'd1;
      ins = {op, 4'($random(seed)), 4'(t), m, 12'($random(seed))};
      ea = 24'(ins[11:0]) + base_v[m] + ((idx_v[t % 8] << sz) >> 1);
      run_ins(ins, 1'b1);
      rd_chk(A_FIELDS, {8'h0, ins[31:12], ins[19:16]}, ALL);
      rd_chk(A_ADDR, {8'h0, ea}, ALL);
      rd_chk(A_CLASS, {8'h0, op[1], op[2], 12'h0, sz, 3'b001, 2'b00, ins[19], |ins[18:16],
        1'b0}, 32'h00c0_032f);
    end
    done("addressing");
    ins = {8'h58, 24'($random(seed))};
    run_ins(ins, 1'b1);
    rd_chk(A_IMM, {16'h0, ins[15:0]}, ALL);
    rd_chk(A_ADDR, 32'h0, ALL);
    foreach (sh_tab[i]) begin
      ins = {sh_tab[i][11:4], 24'($random(seed))};
      run_ins(ins, 1'b1);
      rd_chk(A_CLASS, {20'h0, sh_tab[i][3:0], 8'h48}, 32'h0000_0f49);
      rd_chk(A_IMM, {16'h0, ins[15:0]}, ALL);
    end
    foreach (st_tab[i]) begin
      run_ins({st_tab[i][12:5], 24'($random(seed))}, 1'b1);
      rd_chk(A_CLASS, {10'h0, st_tab[i][4:0], 17'h10}, 32'h003e_0010);
    end
    run_ins({8'h2b, 4'h5, 20'($random(seed))}, 1'b1);
    rd_chk(A_CLASS, 32'h0000_5010, 32'h0000_f010);
    run_ins({8'h2f, 24'($random(seed))}, 1'b1);
    rd_chk(A_CLASS, 32'h0000_8010, 32'h0000_8010);
    done("opcodes");
    for (int i = 0; i < 2; i++) begin
      run_ins({8'hb0, 4'(i), 20'($random(seed))}, 1'b1);
      rd_chk(A_CLASS, {15'h0, i == 0, 16'h0080}, 32'h0001_0081);
      run_ins({(i == 0) ? 8'h00 : 8'hff, 24'($random(seed))}, 1'b0);
      rd_chk(A_CLASS, 32'h1, 32'h1);
    end
    foreach (v_tab[i]) begin
      wb(1'b1, A_CONFIG, {31'h0, v_tab[i][1]});
      wb(1'b1, A_VOP, {24'h0, v_tab[i][9:2]});
      repeat (3) @(posedge clk_i);
      rd_chk(A_VSTAT, {30'h0, 1'b1, v_tab[i][0]}, 32'h3);
    end
    done("vector");
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 32'h4110_0000 : (i == 1) ? 32'hc110_0000 : (i == 2) ? 32'h7f00_0000
        : $random(seed);
      lo = (i == 2) ? 32'h0 : $random(seed);
      wb(1'b1, A_OPHI, w);
      wb(1'b1, A_OPLO, lo);
      rd_chk(A_FLOAT, {w[31], w[30:24] - EXP_BIAS, w[23:0]}, ALL);
      rd_chk(A_HALF_L, {{16{w[31]}}, w[31:16]}, ALL);
      rd_chk(A_HALF_R, {{16{w[15]}}, w[15:0]}, ALL);
      rd_chk(A_SIGNS, {27'h0, |{w[23:0], lo}, w[31], w[15], w[31], w[31]}, ALL);
    end
    done("formats");
    repeat (3) @(posedge clk_i);
    final_report;
  end
endmodule
`default_nettype wire
